// File: src/fsw_status_protect.sv
// status registers, write protection and area guard decode of a serial flash
`timescale 1ns/1ps
module fsw_status_protect #(
  parameter int PROG_CYCLES = 50,
  parameter int ERASE_CYCLES = 400,
  parameter int STATUS_CYCLES = 20
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire fsw_pkg::fsw_cmd_s link_cmd,
  output logic [15:0] link_status,
  input wire logic wp_n,
  output fsw_pkg::fsw_arr_s arr_req,
  output logic quad_io_enable,
  output logic [2:0] secure_lock_bits,
  output logic [15:0] status_word
);

  // link-side state
  typedef struct packed {
    fsw_pkg::fsw_cmd_s hold;
    logic cmd_tgl;
    logic [2:0] st_sync;
    logic st_seen;
    logic ack_tgl;
    logic [15:0] status;
  } fsw_link_s;

  // core-side state
  typedef struct packed {
    logic [2:0] cmd_sync;
    logic cmd_seen;
    logic [2:0] wp_sync;
    logic wp_level;
    logic [2:0] ack_sync;
    logic ack_seen;
    logic st_tgl;
    logic [15:0] mirror;
    logic we_latch;
    logic [4:0] area;
    logic [1:0] guard;
    logic quad;
    logic [2:0] lock;
    logic invert;
    logic erase_paused;
    logic program_paused;
    logic reset_armed;
    fsw_pkg::fsw_busy_e busy_op;
    logic [fsw_pkg::CNT_W-1:0] cnt;
    fsw_pkg::fsw_arr_s arr;
  } fsw_core_s;

  fsw_link_s lnk_q, lnk_d;
  fsw_core_s core_q, core_d;

  logic cmd_event;
  logic st_event;
  logic wp_high;
  logic hw_protected;
  logic status_write_ok;
  logic chip_ok;
  logic addr_protected;
  logic busy;
  logic [15:0] status_now;
  logic is_prog;
  logic is_erase;

  // true when addr falls in the region selected by guards and invert
  function automatic logic in_region(input logic [4:0] area, input logic inv,
                                     input logic [23:0] addr);
    logic [4:0] lg;
    logic [2:0] step;
    logic [fsw_pkg::ADDR_W-1:0] mask;
    logic [fsw_pkg::ADDR_W-1:0] a;
    logic hit;
    a = addr[fsw_pkg::ADDR_W-1:0];
    step = area[2:0];
    if (area[4]) begin
      // fine regions: 4KB doubling, capped at 32KB
      if (step > fsw_pkg::FINE_MAX_STEP) begin
        step = fsw_pkg::FINE_MAX_STEP;
      end
      lg = fsw_pkg::LOG_FINE_BASE + {2'h0, step};
    end else begin
      // coarse regions: 128KB doubling
      lg = fsw_pkg::LOG_COARSE_BASE + {2'h0, step};
    end
    mask = '1;
    mask = mask << lg;
    if (area[2:0] == fsw_pkg::GUARDS_NONE) begin
      hit = 1'b0;
    end else if (area[2:0] == fsw_pkg::GUARDS_ALL) begin
      hit = 1'b1;
    end else if (area[3]) begin
      hit = ((a & mask) == '0); // bottom region
    end else begin
      hit = ((a & mask) == mask); // top region
    end
    // invert takes the complement
    return hit ^ inv;
  endfunction

  // link domain: capture command, publish toggle, receive status mirror
  always_comb begin
    lnk_d = lnk_q;
    lnk_d.st_sync = {lnk_q.st_sync[1:0], core_q.st_tgl};
    if (link_cmd.valid) begin
      lnk_d.hold = link_cmd;
      lnk_d.cmd_tgl = ~lnk_q.cmd_tgl;
    end
    if (st_event) begin
      lnk_d.status = core_q.mirror;
      lnk_d.st_seen = lnk_q.st_sync[2];
      lnk_d.ack_tgl = ~lnk_q.ack_tgl;
    end
  end

  assign st_event = (lnk_q.st_sync[1] == lnk_q.st_sync[2]) &&
                    (lnk_q.st_sync[2] != lnk_q.st_seen);

  // link domain registers
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      lnk_q <= '0;
    end else begin
      lnk_q <= lnk_d;
    end
  end

  assign link_status = lnk_q.status;

  // core combinational terms
  assign cmd_event = (core_q.cmd_sync[1] == core_q.cmd_sync[2]) &&
                     (core_q.cmd_sync[2] != core_q.cmd_seen);
  assign busy = (core_q.busy_op != fsw_pkg::BUSY_NONE) &&
                !core_q.erase_paused && !core_q.program_paused;
  // in quad mode the pin is a data line, so it protects nothing
  assign wp_high = core_q.quad | core_q.wp_level;
  assign hw_protected = (core_q.guard == 2'h1) && !wp_high;
  // guard-high set: power-cycle lock or one-time lock
  assign status_write_ok = core_q.we_latch && !core_q.guard[1] &&
                           !hw_protected;
  assign chip_ok = (core_q.area[2:0] == fsw_pkg::GUARDS_NONE && !core_q.invert) ||
                   (core_q.area[2:0] == fsw_pkg::GUARDS_ALL && core_q.invert);
  assign addr_protected = in_region(core_q.area, core_q.invert,
                                    core_q.arr.addr);
  assign is_prog = (lnk_q.hold.opcode == fsw_pkg::OP_PAGE_WRITE) ||
                   (lnk_q.hold.opcode == fsw_pkg::OP_QUAD_PAGE_WRITE);
  assign is_erase = (lnk_q.hold.opcode == fsw_pkg::OP_SECTOR_CLEAR) ||
                    (lnk_q.hold.opcode == fsw_pkg::OP_BLOCK32_CLEAR) ||
                    (lnk_q.hold.opcode == fsw_pkg::OP_BLOCK64_CLEAR);

  // status word assembly
  always_comb begin
    status_now = '0;
    status_now[fsw_pkg::B_BUSY] = busy;
    status_now[fsw_pkg::B_WE_LATCH] = core_q.we_latch;
    status_now[fsw_pkg::B_AREA_LO +: 5] = core_q.area;
    status_now[fsw_pkg::B_GUARD_LO] = core_q.guard[0];
    status_now[fsw_pkg::B_GUARD_HI] = core_q.guard[1];
    status_now[fsw_pkg::B_QUAD] = core_q.quad;
    status_now[fsw_pkg::B_PROG_PAUSED] = core_q.program_paused;
    status_now[fsw_pkg::B_LOCK_LO +: 3] = core_q.lock;
    status_now[fsw_pkg::B_INVERT] = core_q.invert;
    status_now[fsw_pkg::B_ERASE_PAUSED] = core_q.erase_paused;
  end

  // core next state: synchronisers, command execution, busy timer
  always_comb begin
    core_d = core_q;
    core_d.cmd_sync = {core_q.cmd_sync[1:0], lnk_q.cmd_tgl};
    core_d.ack_sync = {core_q.ack_sync[1:0], lnk_q.ack_tgl};
    core_d.wp_sync = {core_q.wp_sync[1:0], wp_n};
    if (core_q.wp_sync[1] == core_q.wp_sync[2]) begin
      core_d.wp_level = core_q.wp_sync[2];
    end
    core_d.arr.go = 1'b0;
    // status mirror handshake toward the link
    if (core_q.ack_sync[1] == core_q.ack_sync[2]) begin
      core_d.ack_seen = core_q.ack_sync[2];
    end
    if ((core_q.ack_seen == core_q.st_tgl) && (core_q.mirror != status_now)) begin
      core_d.mirror = status_now;
      core_d.st_tgl = ~core_q.st_tgl;
    end
    // busy timer, frozen while paused
    if (busy) begin
      if (core_q.cnt == '0) begin
        core_d.busy_op = fsw_pkg::BUSY_NONE;
      end else begin
        core_d.cnt = core_q.cnt - 1'b1;
      end
    end
    if (cmd_event) begin
      core_d.cmd_seen = core_q.cmd_sync[2];
      core_d.reset_armed = 1'b0;
      case (lnk_q.hold.opcode)
        fsw_pkg::OP_RESET_ARM: begin
          core_d.reset_armed = 1'b1;
        end
        fsw_pkg::OP_RESET_GO: begin
          if (core_q.reset_armed) begin
            core_d.we_latch = 1'b0;
            core_d.erase_paused = 1'b0;
            core_d.program_paused = 1'b0;
            core_d.busy_op = fsw_pkg::BUSY_NONE;
            core_d.cnt = '0;
          end
        end
        fsw_pkg::OP_SUSPEND: begin
          if (busy && core_q.busy_op == fsw_pkg::BUSY_ERASE) begin
            core_d.erase_paused = 1'b1;
          end else if (busy && core_q.busy_op == fsw_pkg::BUSY_PROG) begin
            core_d.program_paused = 1'b1;
          end
        end
        fsw_pkg::OP_RESUME: begin
          core_d.erase_paused = 1'b0;
          core_d.program_paused = 1'b0;
        end
        fsw_pkg::OP_WRITE_UNLOCK: begin
          if (!busy) begin
            core_d.we_latch = 1'b1;
          end
        end
        fsw_pkg::OP_WRITE_LOCK: begin
          if (!busy) begin
            core_d.we_latch = 1'b0;
          end
        end
        fsw_pkg::OP_STATUS_WRITE: begin
          if (core_q.busy_op == fsw_pkg::BUSY_NONE && status_write_ok) begin
            core_d.we_latch = 1'b0;
            core_d.area = lnk_q.hold.data[fsw_pkg::B_AREA_LO +: 5];
            core_d.guard = {lnk_q.hold.data[fsw_pkg::B_GUARD_HI],
                            lnk_q.hold.data[fsw_pkg::B_GUARD_LO]};
            core_d.quad = lnk_q.hold.data[fsw_pkg::B_QUAD];
            core_d.invert = lnk_q.hold.data[fsw_pkg::B_INVERT];
            // lock bits only ever gain ones
            core_d.lock = core_q.lock | lnk_q.hold.data[fsw_pkg::B_LOCK_LO +: 3];
            core_d.busy_op = fsw_pkg::BUSY_STATUS;
            core_d.cnt = fsw_pkg::CNT_W'(STATUS_CYCLES - 1);
          end
        end
        fsw_pkg::OP_CHIP_CLEAR_A, fsw_pkg::OP_CHIP_CLEAR_B: begin
          if (core_q.busy_op == fsw_pkg::BUSY_NONE && core_q.we_latch && chip_ok) begin
            core_d.we_latch = 1'b0;
            core_d.arr = '{go: 1'b1, op: fsw_pkg::ARR_CHIP, addr: '0};
            core_d.busy_op = fsw_pkg::BUSY_ERASE;
            core_d.cnt = fsw_pkg::CNT_W'(ERASE_CYCLES - 1);
          end
        end
        default: begin
          // program and erase: latch address, checked next cycle
          if (core_q.busy_op == fsw_pkg::BUSY_NONE && core_q.we_latch &&
              (is_prog || is_erase)) begin
            core_d.arr.addr = lnk_q.hold.addr;
            core_d.arr.op = is_prog ? fsw_pkg::ARR_PROGRAM :
                            (lnk_q.hold.opcode == fsw_pkg::OP_SECTOR_CLEAR) ?
                            fsw_pkg::ARR_SECTOR : fsw_pkg::ARR_BLOCK;
            core_d.busy_op = is_prog ? fsw_pkg::BUSY_PROG : fsw_pkg::BUSY_ERASE;
            core_d.cnt = '0;
          end
        end
      endcase
    end
    // second cycle of program/erase: protection check then start
    if (core_q.busy_op inside {fsw_pkg::BUSY_PROG, fsw_pkg::BUSY_ERASE} &&
        core_q.we_latch && core_q.cnt == '0 &&
        core_q.arr.op != fsw_pkg::ARR_CHIP) begin
      core_d.we_latch = 1'b0;
      if (addr_protected) begin
        core_d.busy_op = fsw_pkg::BUSY_NONE;
        core_d.cnt = '0;
      end else begin
        core_d.busy_op = core_q.busy_op; // timer must not end the op at its first cycle
        core_d.arr.go = 1'b1;
        core_d.cnt = (core_q.busy_op == fsw_pkg::BUSY_PROG) ?
                     fsw_pkg::CNT_W'(PROG_CYCLES - 1) : fsw_pkg::CNT_W'(ERASE_CYCLES - 1);
      end
    end
  end

  // core registers; power cycle returns every bit to its reset value
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      core_q <= '0;
      core_q.area <= fsw_pkg::AREA_RST;
      core_q.guard <= fsw_pkg::GUARD_RST;
      core_q.lock <= fsw_pkg::LOCK_RST;
      core_q.invert <= fsw_pkg::INVERT_RST;
      core_q.quad <= fsw_pkg::QUAD_RST;
      core_q.wp_level <= 1'b1;
      core_q.wp_sync <= 3'h7;
    end else begin
      core_q <= core_d;
    end
  end

  assign arr_req = core_q.arr;
  assign quad_io_enable = core_q.quad;
  assign secure_lock_bits = core_q.lock;
  assign status_word = core_q.mirror;

  // checks on the core domain
  a_busy_maps_flag: assert property (
    @(posedge clk) disable iff (!reset_n)
    core_q.arr.go |-> (core_q.busy_op != fsw_pkg::BUSY_NONE))
    else $error("array start without busy");

  a_go_needs_open: assert property (
    @(posedge clk) disable iff (!reset_n)
    core_d.arr.go && core_d.arr.op != fsw_pkg::ARR_CHIP |-> !addr_protected)
    else $error("start into protected address");

  a_chip_needs_ok: assert property (
    @(posedge clk) disable iff (!reset_n)
    core_d.arr.go && core_d.arr.op == fsw_pkg::ARR_CHIP |-> chip_ok && core_q.we_latch)
    else $error("chip erase with guards set");

  a_lock_one_time: assert property (
    @(posedge clk) disable iff (!reset_n)
    (($past(core_q.lock) & ~core_q.lock) == 3'h0))
    else $error("lock bit cleared");

  a_guard_hi_frozen: assert property (
    @(posedge clk) disable iff (!reset_n)
    $past(core_q.guard[1]) |-> $stable(core_q.area) && $stable(core_q.guard))
    else $error("status changed under lock");

  a_hw_guard_hold: assert property (
    @(posedge clk) disable iff (!reset_n)
    hw_protected |=> $stable(core_q.area) && $stable(core_q.guard))
    else $error("guards changed under pin protect");

  a_latch_gates_write: assert property (
    @(posedge clk) disable iff (!reset_n)
    !core_q.we_latch && core_q.busy_op == fsw_pkg::BUSY_NONE
      |=> core_q.busy_op != fsw_pkg::BUSY_STATUS)
    else $error("status write without latch");

  a_pause_on_suspend: assert property (
    @(posedge clk) disable iff (!reset_n)
    $rose(core_q.erase_paused) |-> $past(core_q.busy_op) == fsw_pkg::BUSY_ERASE)
    else $error("erase pause without erase");

  a_resume_clears: assert property (
    @(posedge clk) disable iff (!reset_n)
    cmd_event && lnk_q.hold.opcode == fsw_pkg::OP_RESUME
      |=> !core_q.erase_paused && !core_q.program_paused)
    else $error("paused flag kept after resume");

endmodule

// File: common/fsw_pkg.sv
// package: constants and types for the flash status and write-protect block
// Functional notes
// - low status byte: guard-low, five area guards, write latch, busy flag.
// - high status byte: erase paused, invert, three locks, program paused, quad, guard-high.
// - busy flag is one during program, erase or status write, else zero.
// - latch bit shows the latch; status write, program, erase refused when clear.
// - area guards written by status write; select region blocked for program and erase.
// - area guards change only when hardware protection is not in force.
// - chip erase only with guards 2..0 all zero and invert 0, or all one and invert 1.
// - guard bits 00: status write accepted on latch set, pin ignored.
// - guard bits 01: status write blocked while pin low, accepted while pin high.
// - guard bits 10: status writes blocked until power cycle, which returns 00.
// - guard bits 11: status writes refused permanently; here a power cycle returns 00 as for 10.
// - quad enable 0: pins in control role; 1: pins become data lines.
// - lock bits reset zero, set individually, one-time, once set security read-only; here a power cycle clears them to LOCK_RST.
// - invert bit defaults zero and combines with area guards.
// - suspend sets erase-paused or program-paused according to the suspended operation.
// - resume, two-step software reset and power cycle clear both paused flags.
// - invert 1: guards 2..0 000 protect all, 111 protect nothing.
// - invert 1, guards 4,3=00: lower region from zero, shrinking fractions.
// - invert 1, guards 4,3=01: upper region to array top.
// - invert 1, guards 4,3=10: zero up to a fine end address.
// - invert 1, guards 4,3=11: fine start address up to array top.
// - invert 0: guards 11011 bottom 16KB, 1110X or 11110 bottom 32KB.
// - write-unlock sets latch; reset, lock, status write, program, erase clear it.
// - low protect pin is hardware protection of area guards and status-protect bits.
package fsw_pkg;
  // command codes
  localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
  localparam logic [7:0] OP_WRITE_LOCK = 8'h04;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
  localparam logic [7:0] OP_QUAD_PAGE_WRITE = 8'h32;
  localparam logic [7:0] OP_SECTOR_CLEAR = 8'h20;
  localparam logic [7:0] OP_BLOCK32_CLEAR = 8'h52;
  localparam logic [7:0] OP_BLOCK64_CLEAR = 8'hD8;
  localparam logic [7:0] OP_CHIP_CLEAR_A = 8'h60;
  localparam logic [7:0] OP_CHIP_CLEAR_B = 8'hC7;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7A;
  localparam logic [7:0] OP_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_RESET_GO = 8'h99;
  // status bit positions within the 16-bit status word
  localparam int B_BUSY = 0;
  localparam int B_WE_LATCH = 1;
  localparam int B_AREA_LO = 2;
  localparam int B_GUARD_LO = 7;
  localparam int B_GUARD_HI = 8;
  localparam int B_QUAD = 9;
  localparam int B_PROG_PAUSED = 10;
  localparam int B_LOCK_LO = 11;
  localparam int B_INVERT = 14;
  localparam int B_ERASE_PAUSED = 15;
  // array geometry and region sizes as log2 of bytes
  localparam int ADDR_W = 23;
  localparam logic [4:0] LOG_COARSE_BASE = 5'h10;
  localparam logic [4:0] LOG_FINE_BASE = 5'h0B;
  localparam logic [2:0] FINE_MAX_STEP = 3'h4;
  localparam logic [2:0] GUARDS_NONE = 3'h0;
  localparam logic [2:0] GUARDS_ALL = 3'h7;
  // non-volatile reset values
  localparam logic [4:0] AREA_RST = 5'h00;
  localparam logic [1:0] GUARD_RST = 2'h0;
  localparam logic [2:0] LOCK_RST = 3'h0;
  localparam logic INVERT_RST = 1'b0;
  localparam logic QUAD_RST = 1'b0;
  localparam int CNT_W = 24;

  typedef enum logic [1:0] {
    ARR_PROGRAM,
    ARR_SECTOR,
    ARR_BLOCK,
    ARR_CHIP
  } fsw_arr_op_e;

  typedef enum logic [1:0] {
    BUSY_NONE,
    BUSY_PROG,
    BUSY_ERASE,
    BUSY_STATUS
  } fsw_busy_e;

  // one decoded command from the serial framer
  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [15:0] data;
  } fsw_cmd_s;

  // request to the array datapath
  typedef struct packed {
    logic go;
    fsw_arr_op_e op;
    logic [23:0] addr;
  } fsw_arr_s;
endpackage

// File: tb/fsw_host_model.sv
// host-side model: drives decoded commands on a gated link clock
`timescale 1ns/1ps
module fsw_host_model (
  output logic link_clk,
  output fsw_pkg::fsw_cmd_s link_cmd
);
  initial begin
    link_clk = 1'h0;
    link_cmd = '0;
  end

  // clock runs only inside a frame; released fields toggle every cycle
  task automatic frame(input logic v, input logic [7:0] op, input logic [23:0] a,
                       input logic [15:0] d, input int n);
    int i;
    #3.3;
    for (i = 0; i < n; i++) begin
      link_cmd.valid = v && (i == 0); // single-cycle request
      if (v && i == 0) begin
        link_cmd[47:0] = {op, a, d}; // status data travels whole
      end else begin
        link_cmd[47:0] = ~link_cmd[47:0];
      end
      #7.5 link_clk = 1'h1;
      #7.5 link_clk = 1'h0;
    end
  endtask
endmodule

// File: tb/fsw_status_protect_test.sv
// self-checking bench for the status and write-protect block
`timescale 1ns/1ps
module fsw_status_protect_test;
  typedef struct packed {
    logic inv;
    logic [4:0] area;
    logic [23:0] a;
    logic ga;
    logic [23:0] b;
    logic gb;
  } fsw_probe_s;
  logic clk, reset_n, wp_n, link_clk, quad_io_enable, ok;
  logic [15:0] link_status, status_word, exp_st;
  logic [2:0] secure_lock_bits;
  logic [31:0] r;
  fsw_pkg::fsw_cmd_s link_cmd;
  fsw_pkg::fsw_arr_s arr_req;
  logic [15:0] sq[$];
  logic [26:0] aq[$];
  int bad_count = 0;
  int tests_run = 0;
  int seed = 1683;
  int k;
  fsw_probe_s p;
  fsw_probe_s tbl [14] = '{
    '{1'h1, 5'h01, 24'h7DFFFF, 1'h0, 24'h7E0000, 1'h1},
    '{1'h1, 5'h06, 24'h3FFFFF, 1'h0, 24'h400000, 1'h1},
    '{1'h1, 5'h09, 24'h020000, 1'h0, 24'h01FFFF, 1'h1},
    '{1'h1, 5'h0E, 24'h400000, 1'h0, 24'h3FFFFF, 1'h1},
    '{1'h1, 5'h11, 24'h7FEFFF, 1'h0, 24'h7FF000, 1'h1},
    '{1'h1, 5'h15, 24'h7F7FFF, 1'h0, 24'h7F8000, 1'h1},
    '{1'h1, 5'h19, 24'h001000, 1'h0, 24'h000FFF, 1'h1},
    '{1'h1, 5'h1E, 24'h008000, 1'h0, 24'h007FFF, 1'h1},
    '{1'h1, 5'h18, 24'h000000, 1'h0, 24'h7FFFFF, 1'h0},
    '{1'h1, 5'h17, 24'h000000, 1'h1, 24'h7FFFFF, 1'h1},
    '{1'h0, 5'h1B, 24'h003FFF, 1'h0, 24'h004000, 1'h1},
    '{1'h0, 5'h1D, 24'h007FFF, 1'h0, 24'h008000, 1'h1},
    '{1'h0, 5'h00, 24'h000000, 1'h1, 24'h7FFFFF, 1'h1},
    '{1'h0, 5'h07, 24'h000000, 1'h0, 24'h7FFFFF, 1'h0}};

  fsw_status_protect #(.PROG_CYCLES(30), .ERASE_CYCLES(40), .STATUS_CYCLES(4)) DUT (
    .clk(clk), .reset_n(reset_n), .link_clk(link_clk), .link_cmd(link_cmd),
    .link_status(link_status), .wp_n(wp_n), .arr_req(arr_req),
    .quad_io_enable(quad_io_enable), .secure_lock_bits(secure_lock_bits),
    .status_word(status_word));
  fsw_host_model host (.link_clk(link_clk), .link_cmd(link_cmd));

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  task automatic note(input logic good, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (good !== 1'h1) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic comp16(input logic [15:0] got, input logic [15:0] exp);
    note(got === exp, {16'h0, got}, {16'h0, exp});
  endtask
  task automatic comp_arr(input logic [26:0] got, input logic [26:0] exp);
    note(exp[26] ? got === exp : got[25:24] === exp[25:24], {5'h0, got}, {5'h0, exp});
  endtask
  task automatic comp_lvl(input logic [3:0] got, input logic [3:0] exp);
    note(got === exp, {28'h0, got}, {28'h0, exp});
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // power cycle with the link clock ticking inside reset
  task automatic por;
    @(negedge clk);
    reset_n = 1'h0;
    fork
      repeat (6) @(negedge clk);
      host.frame(1'h0, 8'h00, 24'h0, 16'h0, 4);
    join
    reset_n = 1'h1;
    repeat (5) @(negedge clk);
  endtask

  // one command, then wait out busy and let the link side catch up
  task automatic cmd(input logic [7:0] o, input logic [23:0] a, input logic [15:0] d,
                     input logic bz);
    int i;
    fork
      host.frame(1'h1, o, a, d, 14);
      if (bz) begin
        for (i = 0; i < 20 && status_word[0] !== 1'h1; i++) @(negedge clk);
        comp_lvl({3'h0, status_word[0]}, 4'h1);
      end
    join
    for (i = 0; i < 100 && status_word[0] === 1'h1 && status_word[15] !== 1'h1
         && status_word[10] !== 1'h1; i++) begin
      host.frame(1'h0, 8'h00, 24'h0, 16'h0, 2);
    end
    host.frame(1'h0, 8'h00, 24'h0, 16'h0, 12);
  endtask

  task automatic chk(input logic [15:0] e);
    @(negedge clk);
    sq.push_back(e);
  endtask

  task automatic wr(input logic [15:0] d, input logic acc);
    cmd(fsw_pkg::OP_WRITE_UNLOCK, 24'h0, 16'h0, 1'h0);
    cmd(fsw_pkg::OP_STATUS_WRITE, 24'h0, d, acc);
    if (!acc) cmd(fsw_pkg::OP_WRITE_LOCK, 24'h0, 16'h0, 1'h0);
  endtask

  // random kind among program, sector and block; go expected only if g
  task automatic probe(input logic [23:0] a, input logic g);
    r = $random(seed);
    if (r[1:0] == 2'h3) r[1:0] = 2'h0;
    cmd(fsw_pkg::OP_WRITE_UNLOCK, 24'h0, 16'h0, 1'h0);
    if (g) aq.push_back({1'h1, r[1:0], a});
    cmd(r[1:0] == 2'h0 ? fsw_pkg::OP_PAGE_WRITE : r[1:0] == 2'h1 ?
        fsw_pkg::OP_SECTOR_CLEAR : fsw_pkg::OP_BLOCK32_CLEAR, a, 16'h0, 1'h0);
    chk(exp_st);
  endtask

  // status monitor: oldest note against both status views
  initial forever begin
    @(negedge clk);
    while (sq.size() > 0) begin
      comp16(status_word, sq[0]);
      comp16(link_status, sq.pop_front());
    end
  end

  // array request monitor: every go must have been noted
  // sampled mid-cycle so the one-cycle pulse is seen exactly once
  always @(negedge clk) begin
    if (arr_req.go === 1'h1) begin
      if (aq.size() == 0) note(1'h0, {6'h0, arr_req.op, arr_req.addr}, 32'h0);
      else comp_arr({1'h1, arr_req.op, arr_req.addr}, aq.pop_front());
    end
  end

  initial begin
    #1000000;
    bad_count++;
    print_verdict();
  end

  initial begin
    reset_n = 1'h0;
    wp_n = 1'h1;
    por();
    chk(16'h0000);
    cmd(fsw_pkg::OP_STATUS_WRITE, 24'h0, 16'h4004, 1'h0);
    cmd(fsw_pkg::OP_PAGE_WRITE, 24'h000100, 16'h0, 1'h0);
    chk(16'h0000);
    cmd(fsw_pkg::OP_WRITE_UNLOCK, 24'h0, 16'h0, 1'h0);
    chk(16'h0002);
    cmd(fsw_pkg::OP_WRITE_LOCK, 24'h0, 16'h0, 1'h0);
    chk(16'h0000);
    for (k = 0; k < 14; k++) begin
      p = tbl[k];
      exp_st = {1'h0, p.inv, 7'h00, p.area, 2'h0};
      wr(exp_st, 1'h1);
      chk(exp_st);
      probe(p.a, p.ga);
      probe(p.b, p.gb);
      ok = (p.area[2:0] == 3'h0 && !p.inv) || (p.area[2:0] == 3'h7 && p.inv);
      cmd(fsw_pkg::OP_WRITE_UNLOCK, 24'h0, 16'h0, 1'h0);
      if (ok) aq.push_back({1'h0, 2'h3, 24'h0});
      cmd(r[2] ? fsw_pkg::OP_CHIP_CLEAR_A : fsw_pkg::OP_CHIP_CLEAR_B, 24'h0, 16'h0, 1'h0);
      chk(exp_st | {14'h0, ~ok, 1'h0});
      cmd(fsw_pkg::OP_WRITE_LOCK, 24'h0, 16'h0, 1'h0);
    end
    por();
    wr(16'h0080, 1'h1);
    @(negedge clk) wp_n = 1'h0;
    wr(16'h0084, 1'h0);
    chk(16'h0080);
    @(negedge clk) wp_n = 1'h1;
    wr(16'h0280, 1'h1);
    comp_lvl({3'h0, quad_io_enable}, 4'h1);
    @(negedge clk) wp_n = 1'h0;
    wr(16'h0284, 1'h1);
    chk(16'h0284);
    @(negedge clk) wp_n = 1'h1;
    wr(16'h2800, 1'h1);
    wr(16'h1000, 1'h1);
    chk(16'h3800);
    comp_lvl({1'h0, secure_lock_bits}, 4'h7);
    wr(16'h3900, 1'h1);
    wr(16'h3804, 1'h0);
    chk(16'h3900);
    por();
    chk(16'h0000);
    wr(16'h0180, 1'h1);
    wr(16'h0000, 1'h0);
    chk(16'h0180);
    por();
    cmd(fsw_pkg::OP_WRITE_UNLOCK, 24'h0, 16'h0, 1'h0);
    aq.push_back({1'h1, 2'h1, 24'h010000});
    host.frame(1'h1, fsw_pkg::OP_SECTOR_CLEAR, 24'h010000, 16'h0, 14);
    cmd(fsw_pkg::OP_SUSPEND, 24'h0, 16'h0, 1'h0);
    comp_lvl({3'h0, status_word[15]}, 4'h1);
    cmd(fsw_pkg::OP_RESUME, 24'h0, 16'h0, 1'h0);
    chk(16'h0000);
    cmd(fsw_pkg::OP_WRITE_UNLOCK, 24'h0, 16'h0, 1'h0);
    aq.push_back({1'h1, 2'h0, 24'h000200});
    host.frame(1'h1, fsw_pkg::OP_PAGE_WRITE, 24'h000200, 16'h0, 14);
    cmd(fsw_pkg::OP_SUSPEND, 24'h0, 16'h0, 1'h0);
    comp_lvl({3'h0, status_word[10]}, 4'h1);
    cmd(fsw_pkg::OP_RESET_ARM, 24'h0, 16'h0, 1'h0);
    cmd(fsw_pkg::OP_RESET_GO, 24'h0, 16'h0, 1'h0);
    comp_lvl({2'h0, status_word[15], status_word[10]}, 4'h0);
    por();
    repeat (4) @(negedge clk);
    note(aq.size() == 0, 32'(aq.size()), 32'h0);
    print_verdict();
  end
endmodule
